// ---- rtl/chan_modem_pkg.sv ----
// constants, types and default tables for the channel function and modem host block
// Overview of operation
// [RL1] A 4-bit code 0000..1100 written to the function register selects the channel function.
// [RL2] Each function code write loads default conversion and comparator settings.
// [RL3] Voltage output: input select 01, span 010, comparator off, level 0.
// [RL4] Current input external power, with or without modem: 01, 011, on, 0x49.
// [RL5] Current input loop power, with or without modem: 01, 100, on, 0x49.
// [RL6] Three or four wire probe: input select 11, span 101, comparator off, 0.
// [RL7] Two wire resistance: input select 00, span 100, comparator off, level 0.
// [RL8] Digital input, logic or loop powered: 00, 000, comparator on, level 0x49.
// [RL9] High-Z, current out, voltage in, current out with modem: all zero.
// [RL10] Every function write clears wiring, sink, reference and sets excitation to 11.
// [RL11] Reset sets reset flag, alert pin low; write one clears; software clears first.
// [RL12] Separate send and receive queues, 32 bytes each.
// [RL13] Writing the send port pushes a byte; reading the receive port pops one.
// [RL14] Send fill count below its low level raises a send-level event.
// [RL15] Receive fill count above its high level raises a receive-level event.
// [RL16] Both queue fill counts are readable in separate registers.
// [RL17] Any modem event flag set raises the modem summary in the alert status.
// [RL18] Suppressed modem events are still recorded but do not drive the alert pin.
// [RL19] Host register accesses become byte transfers to and from the modem.
// [RL20] Host picks modem function, waits 200 us, powers modem, fills queue, clears.
// [RL21] Setting request-to-send starts sending the queued bytes.
// [RL22] Host enables the paired sinking slot when measuring sourcing current.
// [RL23] Pushes to a full send queue are dropped; empty receive reads give zero.
package chan_modem_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_FUNC = 8'h00;
   localparam logic [7:0] OFS_CONV = 8'h04;
   localparam logic [7:0] OFS_COMP = 8'h08;
   localparam logic [7:0] OFS_PROBE = 8'h0C;
   localparam logic [7:0] OFS_LOGIC_IN = 8'h10;
   localparam logic [7:0] OFS_ALERT = 8'h14;
   localparam logic [7:0] OFS_EVT = 8'h18;
   localparam logic [7:0] OFS_SUPP = 8'h1C;
   localparam logic [7:0] OFS_QCTL = 8'h20;
   localparam logic [7:0] OFS_TXQ = 8'h24;
   localparam logic [7:0] OFS_RXQ = 8'h28;
   localparam logic [7:0] OFS_TXCNT = 8'h2C;
   localparam logic [7:0] OFS_RXCNT = 8'h30;
   localparam logic [7:0] OFS_SETUP = 8'h34;
   localparam logic [7:0] OFS_LINE = 8'h38;
   // function codes
   localparam logic [3:0] FN_VOUT = 4'h1;
   localparam logic [3:0] FN_IIN_EXT = 4'h4;
   localparam logic [3:0] FN_IIN_LOOP = 4'h5;
   localparam logic [3:0] FN_RES2W = 4'h6;
   localparam logic [3:0] FN_RTD = 4'h7;
   localparam logic [3:0] FN_DIN = 4'h8;
   localparam logic [3:0] FN_DIN_LOOP = 4'h9;
   localparam logic [3:0] FN_IIN_EXT_M = 4'hB;
   localparam logic [3:0] FN_LAST = 4'hC;
   // alert status and modem event bit positions
   localparam int AL_RESET = 0;
   localparam int AL_MODEM = 1;
   localparam int EV_RX_HIGH = 0;
   localparam int EV_TX_LOW = 1;
   localparam int EV_RX_OVF = 2;
   localparam int EV_FRAME = 3;
   localparam int EV_TX_DONE = 4;
   localparam int EV_W = 5;
   // queue geometry and reset levels
   localparam logic [5:0] QDEPTH = 6'h20;
   localparam logic [5:0] TX_LVL_RST = 6'h01;
   localparam logic [5:0] RX_LVL_RST = 6'h1F;
   localparam logic [1:0] EXC_DEFAULT = 2'h3;
   localparam logic [7:0] LVL_MID = 8'h49;

   typedef struct packed {
      logic [1:0] primary_conversion_input_select;
      logic [2:0] primary_conversion_span;
      logic input_comparator_on;
      logic [7:0] input_comparator_level;
   } conv_defaults_t;

   typedef struct packed {
      logic [3:0] channel_function_select;
      conv_defaults_t conv;
      logic resistive_probe_wiring_select;
      logic [1:0] resistive_probe_excitation;
      logic input_sink_on;
      logic logic_input_level_reference;
   } front_end_cfg_t;

   localparam conv_defaults_t DEF_ZERO = '{2'h0, 3'h0, 1'b0, 8'h00};
   localparam conv_defaults_t DEF_VOUT = '{2'h1, 3'h2, 1'b0, 8'h00};
   localparam conv_defaults_t DEF_IIN_EXT = '{2'h1, 3'h3, 1'b1, LVL_MID};
   localparam conv_defaults_t DEF_IIN_LOOP = '{2'h1, 3'h4, 1'b1, LVL_MID};
   localparam conv_defaults_t DEF_RES2W = '{2'h0, 3'h4, 1'b0, 8'h00};
   localparam conv_defaults_t DEF_RTD = '{2'h3, 3'h5, 1'b0, 8'h00};
   localparam conv_defaults_t DEF_DIN = '{2'h0, 3'h0, 1'b1, LVL_MID};
   localparam front_end_cfg_t FE_RST = '{4'h0, DEF_ZERO, 1'b0, EXC_DEFAULT, 1'b0, 1'b0};

   typedef enum logic [3:0] {
      U_IDLE = 4'b0001,
      U_START = 4'b0010,
      U_DATA = 4'b0100,
      U_STOP = 4'b1000
   } uart_state_t;

   // conversion defaults for a function code
   function automatic conv_defaults_t fn_defaults(input logic [3:0] code);
      conv_defaults_t d;
      d = DEF_ZERO; // [RL9]
      case (code)
         FN_VOUT: d = DEF_VOUT; // [RL3]
         FN_IIN_EXT, FN_IIN_EXT_M: d = DEF_IIN_EXT; // [RL4]
         FN_IIN_LOOP, FN_LAST: d = DEF_IIN_LOOP; // [RL5]
         FN_RES2W: d = DEF_RES2W; // [RL7]
         FN_RTD: d = DEF_RTD; // [RL6]
         FN_DIN, FN_DIN_LOOP: d = DEF_DIN; // [RL8]
         default: d = DEF_ZERO;
      endcase
      return d;
   endfunction
endpackage

// ---- rtl/chan_modem_regs.sv ----
// register bank, modem queues and serial bridge for one configurable channel
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module chan_modem_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic modem_clk,
   input wire logic modem_rxd,
   output logic modem_txd,
   output chan_modem_pkg::front_end_cfg_t front_end,
   output logic alert_n
);
   import chan_modem_pkg::*;

   logic take, wr, rd_acc, rd_got;
   logic reset_occ, modem_on, rts;
   logic [EV_W-1:0] evt, suppress, evt_set, evt_clr;
   logic [5:0] tx_lvl, rx_lvl;
   logic [7:0] tx_mem [32];
   logic [7:0] rx_mem [32];
   logic [4:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [5:0] tx_cnt, rx_cnt;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [2:0] lclk_s;
   logic [1:0] rxd_s;
   logic link_edge;
   uart_state_t tx_st, rx_st;
   logic [7:0] tx_sh, rx_sh;
   logic [2:0] tx_bit, rx_bit;

   // request seen while waiting, accepted on the next edge
   assign take = (read | write) & waitrequest;
   assign wr = write & ~waitrequest & byteenable[0];
   assign rd_acc = read & ~waitrequest;

   // one wait cycle per access
   always_ff @(posedge mclk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~take; // [RL19]
      end
   end

   // front end configuration and function defaults
   always_ff @(posedge mclk) begin
      if (rst) begin
         front_end <= FE_RST;
      end else if (wr) begin
         case (address)
            OFS_FUNC: begin
               if (writedata[3:0] <= FN_LAST) begin // [RL1]
                  front_end.channel_function_select <= writedata[3:0];
                  front_end.conv <= fn_defaults(writedata[3:0]); // [RL2]
                  front_end.resistive_probe_wiring_select <= 1'b0; // [RL10]
                  front_end.resistive_probe_excitation <= EXC_DEFAULT; // [RL10]
                  front_end.input_sink_on <= 1'b0; // [RL10]
                  front_end.logic_input_level_reference <= 1'b0; // [RL10]
               end
            end
            OFS_CONV: begin
               front_end.conv.primary_conversion_input_select <= writedata[1:0];
               front_end.conv.primary_conversion_span <= writedata[4:2];
            end
            OFS_COMP: begin
               front_end.conv.input_comparator_level <= writedata[7:0];
               front_end.conv.input_comparator_on <= writedata[8];
            end
            OFS_PROBE: begin
               front_end.resistive_probe_wiring_select <= writedata[0];
               front_end.resistive_probe_excitation <= writedata[2:1];
            end
            OFS_LOGIC_IN: begin
               front_end.input_sink_on <= writedata[0];
               front_end.logic_input_level_reference <= writedata[1];
            end
            default: ;
         endcase
      end
   end

   // plain control registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         suppress <= '0;
         tx_lvl <= TX_LVL_RST;
         rx_lvl <= RX_LVL_RST;
         modem_on <= 1'b0;
         rts <= 1'b0;
      end else if (wr) begin
         case (address)
            OFS_SUPP: suppress <= writedata[EV_W-1:0];
            OFS_QCTL: begin
               tx_lvl <= writedata[5:0];
               rx_lvl <= writedata[13:8];
            end
            OFS_SETUP: modem_on <= writedata[0];
            OFS_LINE: rts <= writedata[0];
            default: ;
         endcase
      end
   end

   // reset flag, cleared only by writing one
   always_ff @(posedge mclk) begin
      if (rst) begin
         reset_occ <= 1'b1; // [RL11]
      end else if (wr && address == OFS_ALERT && writedata[AL_RESET]) begin
         reset_occ <= 1'b0; // [RL11]
      end
   end

   // sticky modem events, a new event wins over a clear
   assign evt_clr = (wr && address == OFS_EVT) ? writedata[EV_W-1:0] : '0;
   always_comb begin
      evt_set = '0;
      evt_set[EV_RX_HIGH] = rx_cnt > rx_lvl; // [RL15]
      evt_set[EV_TX_LOW] = tx_cnt < tx_lvl; // [RL14]
      evt_set[EV_RX_OVF] = link_edge && rx_st == U_STOP && rxd_s[1] && rx_cnt == QDEPTH;
      evt_set[EV_FRAME] = link_edge && rx_st == U_STOP && !rxd_s[1];
      evt_set[EV_TX_DONE] = link_edge && tx_st == U_STOP && tx_cnt == 6'h00;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         evt <= '0;
      end else begin
         evt <= (evt & ~evt_clr) | evt_set;
      end
   end

   // alert pin: reset flag or any unsuppressed event
   always_ff @(posedge mclk) begin
      if (rst) begin
         alert_n <= 1'b0;
      end else begin
         alert_n <= ~(reset_occ | (|(evt & ~suppress))); // [RL11] [RL18]
      end
   end

   // send queue
   assign tx_push = wr && address == OFS_TXQ && tx_cnt != QDEPTH; // [RL13] [RL23]
   always_ff @(posedge mclk) begin
      if (tx_push) begin
         tx_mem[tx_wp] <= writedata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
      end else begin
         if (tx_push) begin
            tx_wp <= tx_wp + 5'd1;
         end
         if (tx_pop) begin
            tx_rp <= tx_rp + 5'd1;
         end
         tx_cnt <= tx_cnt + 6'(tx_push) - 6'(tx_pop); // [RL12]
      end
   end

   // receive queue
   assign rx_push = link_edge && rx_st == U_STOP && rxd_s[1] && rx_cnt != QDEPTH;
   assign rx_pop = rd_acc && address == OFS_RXQ && rd_got; // [RL13] [RL23]
   always_ff @(posedge mclk) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= rx_sh;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
      end else begin
         if (rx_push) begin
            rx_wp <= rx_wp + 5'd1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 5'd1;
         end
         rx_cnt <= rx_cnt + 6'(rx_push) - 6'(rx_pop); // [RL12]
      end
   end

   // read data captured when the request is first seen
   always_ff @(posedge mclk) begin
      if (rst) begin
         readdata <= '0;
         rd_got <= 1'b0;
      end else if (take && read) begin
         rd_got <= address == OFS_RXQ && rx_cnt != 6'h00;
         case (address)
            OFS_FUNC: readdata <= {28'h000_0000, front_end.channel_function_select};
            OFS_CONV: readdata <= {27'h000_0000, front_end.conv.primary_conversion_span,
               front_end.conv.primary_conversion_input_select};
            OFS_COMP: readdata <= {23'h00_0000, front_end.conv.input_comparator_on,
               front_end.conv.input_comparator_level};
            OFS_PROBE: readdata <= {29'h0000_0000, front_end.resistive_probe_excitation,
               front_end.resistive_probe_wiring_select};
            OFS_LOGIC_IN: readdata <= {30'h0000_0000, front_end.logic_input_level_reference,
               front_end.input_sink_on};
            OFS_ALERT: readdata <= {30'h0000_0000, |evt, reset_occ}; // [RL17]
            OFS_EVT: readdata <= {27'h000_0000, evt}; // [RL18]
            OFS_SUPP: readdata <= {27'h000_0000, suppress};
            OFS_QCTL: readdata <= {18'h0_0000, rx_lvl, 2'h0, tx_lvl};
            OFS_RXQ: readdata <= (rx_cnt != 6'h00) ? {24'h00_0000, rx_mem[rx_rp]} : '0; // [RL23]
            OFS_TXCNT: readdata <= {26'h000_0000, tx_cnt}; // [RL16]
            OFS_RXCNT: readdata <= {26'h000_0000, rx_cnt}; // [RL16]
            OFS_SETUP: readdata <= {31'h0000_0000, modem_on};
            OFS_LINE: readdata <= {31'h0000_0000, rts};
            default: readdata <= '0;
         endcase
      end
   end

   // link clock and receive line synchronisers
   always_ff @(posedge mclk) begin
      if (rst) begin
         lclk_s <= '0;
         rxd_s <= 2'b11;
      end else begin
         lclk_s <= {lclk_s[1:0], modem_clk};
         rxd_s <= {rxd_s[0], modem_rxd};
      end
   end
   assign link_edge = lclk_s[1] & ~lclk_s[2];

   // byte sender: start, eight bits low first, stop
   assign tx_pop = link_edge && tx_st == U_IDLE && modem_on && rts && tx_cnt != 6'h00;
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_st <= U_IDLE;
         tx_sh <= '0;
         tx_bit <= '0;
         modem_txd <= 1'b1;
      end else if (link_edge) begin
         unique case (tx_st)
            U_IDLE: begin
               if (tx_pop) begin // [RL21]
                  tx_sh <= tx_mem[tx_rp];
                  modem_txd <= 1'b0;
                  tx_st <= U_START;
               end
            end
            U_START: begin
               modem_txd <= tx_sh[0];
               tx_sh <= tx_sh >> 1;
               tx_bit <= 3'd1;
               tx_st <= U_DATA;
            end
            U_DATA: begin
               if (tx_bit == 3'd0) begin
                  modem_txd <= 1'b1;
                  tx_st <= U_STOP;
               end else begin
                  modem_txd <= tx_sh[0];
                  tx_sh <= tx_sh >> 1;
                  tx_bit <= tx_bit + 3'd1;
               end
            end
            U_STOP: tx_st <= U_IDLE;
         endcase
      end
   end

   // byte receiver, sampled on each link clock rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_st <= U_IDLE;
         rx_sh <= '0;
         rx_bit <= '0;
      end else if (!modem_on) begin
         rx_st <= U_IDLE;
      end else if (link_edge) begin
         unique case (rx_st)
            U_IDLE: if (!rxd_s[1]) rx_st <= U_START;
            U_START: begin
               rx_sh <= {rxd_s[1], rx_sh[7:1]};
               rx_bit <= 3'd1;
               rx_st <= U_DATA;
            end
            U_DATA: begin
               rx_sh <= {rxd_s[1], rx_sh[7:1]};
               rx_bit <= rx_bit + 3'd1;
               if (rx_bit == 3'd7) rx_st <= U_STOP;
            end
            U_STOP: rx_st <= U_IDLE; // [RL19]
         endcase
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_fn(logic [3:0] c);
      write && !waitrequest && byteenable[0] && address == OFS_FUNC && writedata[3:0] == c;
   endsequence

   property p_wait_answer;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no one-wait answer"); // [RL19]

   property p_vout;
      s_fn(FN_VOUT) |=> front_end.conv == DEF_VOUT && front_end.channel_function_select == 4'h1;
   endproperty
   a_vout: assert property (p_vout) else $error("voltage output defaults wrong"); // [RL3]

   property p_rtd;
      s_fn(FN_RTD) |=> front_end.conv.primary_conversion_input_select == 2'h3
         && front_end.conv.primary_conversion_span == 3'h5;
   endproperty
   a_rtd: assert property (p_rtd) else $error("probe defaults wrong"); // [RL6]

   property p_forced;
      s_fn(FN_IIN_EXT_M) |=> front_end.resistive_probe_excitation == 2'h3
         && !front_end.input_sink_on && front_end.conv.input_comparator_level == 8'h49;
   endproperty
   a_forced: assert property (p_forced) else $error("forced fields wrong"); // [RL10]

   property p_tx_push;
      tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 6'h01;
   endproperty
   a_tx_push: assert property (p_tx_push) else $error("send count not bumped"); // [RL13]

   property p_rx_empty;
      read && waitrequest && address == OFS_RXQ && rx_cnt == 6'h00 |=> readdata == '0;
   endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("empty read not zero"); // [RL23]

   property p_tx_low;
      tx_cnt < tx_lvl |=> evt[EV_TX_LOW];
   endproperty
   a_tx_low: assert property (p_tx_low) else $error("send low event missing"); // [RL14]

   property p_rx_high;
      rx_cnt > rx_lvl |=> evt[EV_RX_HIGH];
   endproperty
   a_rx_high: assert property (p_rx_high) else $error("receive high event missing"); // [RL15]

   property p_alert;
      |(evt & ~suppress) |=> !alert_n;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not driven"); // [RL17]

   property p_masked;
      !reset_occ && (evt & ~suppress) == '0 |=> alert_n;
   endproperty
   a_masked: assert property (p_masked) else $error("suppressed event drove alert"); // [RL18]

   property p_rts_start;
      tx_pop |=> tx_st == U_START && !modem_txd;
   endproperty
   a_rts_start: assert property (p_rts_start) else $error("send did not start"); // [RL21]
endmodule // chan_modem_regs

// ---- verification/modem_model.sv ----
// link clock and serial data model of the modem on the far side
`timescale 1ns/100ps
module modem_model (
   output logic modem_clk,
   output logic modem_rxd,
   input wire logic modem_txd
);
   // clock stands low and data idles high between frames
   initial begin
      modem_clk = 1'b0;
      modem_rxd = 1'b1;
   end

   // eleven link clocks: sends one byte lsb first, samples what the block sends
   // the block's sender rests one extra clock in its idle state after the stop bit before the next byte
   // link edges fall midway between system clock edges, so the synchronisers never race
   task automatic frame(input logic [7:0] b, input logic stop_ok, output logic [9:0] seen);
      logic [11:0] bits;
      bits = {2'b11, stop_ok, b, 1'b0};
      #3 modem_rxd = bits[0];
      #12;
      for (int i = 0; i < 11; i++) begin
         modem_clk = 1'b1;
         #80 modem_clk = 1'b0;
         modem_rxd = bits[i + 1]; // data moves just after the falling edge
         #60;
         if (i < 10) seen[i] = modem_txd; // sender output settled well after its edge
         #20;
      end
      #5; // keeps a frame a whole number of system clocks long
   endtask
endmodule // modem_model

// ---- verification/tb_top.sv ----
// self-checking bench for the channel function and modem register block
`timescale 1ns/100ps
module tb_top;
   import chan_modem_pkg::*;
   logic mclk, rst, read, write, waitrequest, modem_clk, modem_rxd, modem_txd, alert_n;
   logic [7:0] address;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable;
   front_end_cfg_t front_end;
   int errors = 0;
   int samples_checked = 0;

   chan_modem_regs DUT (
      .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .modem_clk(modem_clk), .modem_rxd(modem_rxd),
      .modem_txd(modem_txd), .front_end(front_end), .alert_n(alert_n)
   );

   modem_model modem (.modem_clk(modem_clk), .modem_rxd(modem_rxd), .modem_txd(modem_txd));

   // 50 mhz system clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   // read a register and compare the masked value
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
   endtask

   // expected conversion and comparator settings per function code
   function automatic conv_defaults_t exp_conv(input logic [3:0] c);
      case (c)
         4'h1: return {2'h1, 3'h2, 1'b0, 8'h00};
         4'h4, 4'hB: return {2'h1, 3'h3, 1'b1, 8'h49};
         4'h5, 4'hC: return {2'h1, 3'h4, 1'b1, 8'h49};
         4'h7: return {2'h3, 3'h5, 1'b0, 8'h00};
         4'h6: return {2'h0, 3'h4, 1'b0, 8'h00};
         4'h8, 4'h9: return {2'h0, 3'h0, 1'b1, 8'h49};
         default: return {2'h0, 3'h0, 1'b0, 8'h00};
      endcase
   endfunction

   // reset values and write-one-clear of the reset flag
   task automatic t_reset;
      chk(32'(front_end), 32'(FE_RST));
      chk(32'(alert_n), 32'h0000_0000);
      rchk(OFS_ALERT, 32'h0000_0001, 32'h0000_0001);
      rchk(OFS_QCTL, 32'h0000_3F3F, {18'h0_0000, RX_LVL_RST, 2'h0, TX_LVL_RST});
      bus(1'b1, OFS_SUPP, 32'h0000_001F);
      bus(1'b1, OFS_ALERT, 32'h0000_0001);
      repeat (3) @(negedge mclk);
      chk(32'(alert_n), 32'h0000_0001);
      rchk(OFS_ALERT, 32'h0000_0001, 32'h0000_0000);
   endtask

   // codes 0x0 to 0xD, with stale side fields set first; code 0xD and lane-off writes refused
   task automatic t_functions;
      logic [3:0] k;
      logic x;
      front_end_cfg_t e;
      for (int c = 0; c < 14; c++) begin
         bus(1'b1, OFS_PROBE, 32'h0000_0007);
         bus(1'b1, OFS_LOGIC_IN, 32'h0000_0003);
         bus(1'b1, OFS_FUNC, 32'(c));
         repeat (2) @(negedge mclk);
         x = (c == 13);
         k = x ? 4'hC : c[3:0];
         e = {k, exp_conv(k), x, 2'h3, x, x};
         chk(32'(front_end), 32'(e));
      end
      byteenable <= 4'hE;
      bus(1'b1, OFS_FUNC, 32'h0000_0000);
      byteenable <= 4'hF;
      repeat (2) @(negedge mclk);
      chk(32'(front_end.channel_function_select), 32'h0000_000C);
      bus(1'b1, OFS_CONV, 32'h0000_001B);
      bus(1'b1, OFS_COMP, 32'h0000_01AB);
      rchk(OFS_CONV, 32'h0000_001F, 32'h0000_001B);
      rchk(OFS_COMP, 32'h0000_01FF, 32'h0000_01AB);
      bus(1'b1, OFS_FUNC, 32'h0000_0004);
      rchk(OFS_FUNC, 32'h0000_000F, 32'h0000_0004);
      rchk(OFS_CONV, 32'h0000_001F, 32'h0000_000D);
      rchk(OFS_COMP, 32'h0000_01FF, 32'h0000_0149);
   endtask

   // host bring-up order, then fill the send queue past its depth
   task automatic t_queue;
      bus(1'b1, OFS_FUNC, 32'h0000_000B);
      repeat (10000) @(posedge mclk);
      bus(1'b1, OFS_SETUP, 32'h0000_0001);
      bus(1'b1, OFS_QCTL, 32'h0000_1F04);
      for (int i = 0; i < 33; i++) bus(1'b1, OFS_TXQ, 32'(8'(i * 7 + 3)));
      rchk(OFS_TXCNT, 32'h0000_003F, 32'(QDEPTH));
      rchk(OFS_RXQ, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk(OFS_RXCNT, 32'h0000_003F, 32'h0000_0000);
      rchk(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
      bus(1'b1, OFS_EVT, 32'h0000_001F);
      rchk(OFS_EVT, 32'h0000_001F, 32'h0000_0000);
   endtask

   // full-duplex traffic, events, suppression and draining the receive queue
   task automatic t_link;
      logic [9:0] seen;
      bus(1'b1, OFS_LINE, 32'h0000_0001);
      for (int i = 0; i < 32; i++) begin
         modem.frame(8'hA0 + 8'(i), 1'b1, seen);
         chk(32'(seen), 32'({1'b1, 8'(i * 7 + 3), 1'b0}));
      end
      modem.frame(8'h55, 1'b0, seen);
      modem.frame(8'hAA, 1'b1, seen);
      rchk(OFS_TXCNT, 32'h0000_003F, 32'h0000_0000);
      rchk(OFS_RXCNT, 32'h0000_003F, 32'(QDEPTH));
      rchk(OFS_EVT, 32'h0000_001F, 32'h0000_001F);
      rchk(OFS_ALERT, 32'h0000_0002, 32'h0000_0002);
      chk(32'(alert_n), 32'h0000_0001);
      bus(1'b1, OFS_SUPP, 32'h0000_0017);
      repeat (3) @(negedge mclk);
      chk(32'(alert_n), 32'h0000_0000);
      bus(1'b1, OFS_SUPP, 32'h0000_001F);
      for (int i = 0; i < 32; i++) rchk(OFS_RXQ, 32'h0000_00FF, 32'(8'hA0 + 8'(i)));
      rchk(OFS_RXCNT, 32'h0000_003F, 32'h0000_0000);
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      t_reset();
      t_functions();
      t_queue();
      t_link();
      stop_test();
   end

   // watchdog against a hung handshake
   initial begin
      #2000000;
      errors++;
      stop_test();
   end
endmodule // tb_top
